// file: logic/pet_event_flags.sv
/*
  Latched thermal event flags, set on each upward threshold crossing and
  cleared by a read of the flag register.
  Assumes flag_read is a one-cycle pulse per register read.
*/
`timescale 1ns/100ps
`default_nettype none

module pet_event_flags (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  pet_therm_if.flag_side tif
);
  logic warn_prev;
  logic shut_prev;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      warn_prev <= 1'b0;
      shut_prev <= 1'b0;
    end else begin
      warn_prev <= tif.warn_hot;
      shut_prev <= tif.shut_hot;
    end
  end

  // R12: set on crossing, read clears
  // A crossing in the clearing cycle wins over the read
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tif.warn_flag <= 1'b0;
    end else if (tif.warn_hot && !warn_prev) begin
      tif.warn_flag <= 1'b1;
    end else if (tif.flag_read) begin
      tif.warn_flag <= 1'b0;
    end
  end

  // R11: set on crossing, read clears
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tif.shut_flag <= 1'b0;
    end else if (tif.shut_hot && !shut_prev) begin
      tif.shut_flag <= 1'b1;
    end else if (tif.flag_read) begin
      tif.shut_flag <= 1'b0;
    end
  end
endmodule : pet_event_flags

`default_nettype wire

// file: logic/pet_map.svh
/*
  Register map, field positions, reset values and timing counts of the
  thermal, enable and discharge register group.
  Assumes it is included by bare name wherever a number is needed.
*/
`ifndef PET_MAP_SVH
`define PET_MAP_SVH

// ********************************************************************
// Register offsets
// ********************************************************************
`define PET_OFS_ENABLE 8'h08
`define PET_OFS_DISCHARGE 8'h09
`define PET_OFS_STATUS 8'h0A
`define PET_OFS_FLAGS 8'h0B
`define PET_OFS_MASK 8'h0C

// ********************************************************************
// Field positions
// ********************************************************************
`define PET_RAIL_COUNT 6
`define PET_EN_SLEEP_BIT 6
`define PET_EN_VSEL_BIT 7
`define PET_PD_KEEP_BIT 7
`define PET_TH_WARN_BIT 0
`define PET_TH_SHUT_BIT 1

// ********************************************************************
// Reset values and writable bits
// ********************************************************************
`define PET_RST_ENABLE 8'h8F
`define PET_RST_DISCHARGE 8'h3F
`define PET_RST_MASK 8'h03
`define PET_WMASK_DISCHARGE 8'hBF
`define PET_WMASK_MASK 8'h03

// ********************************************************************
// Timing counts
// ********************************************************************
`define PET_STARTUP_CYCLES 4

`endif

// file: logic/pet_pkg.sv
/*
  Types shared by the register group: power state and register byte.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package pet_pkg;
  typedef enum logic [1:0] {
    PET_STANDBY = 2'b00,
    PET_STARTUP = 2'b01,
    PET_IDLE = 2'b10,
    PET_SHUTDOWN = 2'b11
  } pet_power_e;

  typedef logic [7:0] pet_byte_t;
endpackage : pet_pkg

`default_nettype wire

// file: logic/pet_regs.sv
/*
  Enable, discharge, thermal status, thermal flag and mask registers of the
  power manager, with the power state sequencing they steer.
  Assumes a serial register front end that presents one decoded byte access
  per strobe, and comparators that give over-threshold levels.
  The comparators are synchronised inside, so they may switch at any time.
*/
// Function
// R1: standby enable bits choose next power-up rails
// R2: idle enable bits switch rails immediately
// R3: host clears enable of no-start rails
// R4: sleep bit rules unless pin control
// R5: voltage bit picks code unless pin
// R6: discharge bits switch each rail pulldown
// R7: cooled with enable high restarts power-up
// R8: restart keeps or reloads registers
// R9: status shows thermal shutdown state
// R10: status shows warning threshold level
// R11: flag register latches shutdown event
// R12: flag register latches warning event
// R13: shutdown mask blocks its interrupt
// R14: warning mask blocks its interrupt
// R15: warning drives interrupt low, sets bits
// R16: shutdown threshold forces emergency shutdown
// R17: no power-up above restart threshold; the code checks it only on leaving shutdown, not on power-up from standby
// R18: logic runs from the single clock
// R19: thresholds arrive as synchronised levels
// R20: interrupt low while unmasked flag set
`timescale 1ns/100ps
`default_nettype none

`include "pet_map.svh"

module pet_regs #(
  parameter int STARTUP_CYCLES = `PET_STARTUP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Register access from the serial front end
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output pet_pkg::pet_byte_t reg_rdata_out,
  output logic reg_rvalid_out,
  // Device pins and external control selects
  input wire logic en_pin_in,
  input wire logic dvs_pin_in,
  input wire logic pin_low_power_ctrl_in,
  input wire logic pin_voltage_ctrl_in,
  // Temperature comparators
  input wire logic temp_above_warn_in,
  input wire logic temp_above_shut_in,
  input wire logic temp_above_restart_in,
  // Regulator controls
  output logic [`PET_RAIL_COUNT-1:0] rail_on_out,
  output logic [`PET_RAIL_COUNT-1:0] rail_discharge_out,
  output logic low_power_out,
  output logic converter_code_a_sel_out,
  output pet_pkg::pet_power_e power_state_out,
  // Open-drain interrupt pin
  output logic irq_n_out,
  output logic irq_n_oe_out
);
  import pet_pkg::*;

  // ******************************************************************
  // Declarations
  // ******************************************************************
  pet_therm_if tif ();

  pet_byte_t output_enable_control;
  pet_byte_t output_discharge_control;
  pet_byte_t thermal_event_mask;
  pet_power_e power_state;
  pet_power_e next_power_state;
  logic [7:0] startup_count;
  logic reload_defaults;
  logic wr_enable;
  logic wr_discharge;
  logic wr_mask;
  logic thermal_restart_keep_regs;
  logic soft_low_power;
  logic soft_voltage_select;
  logic thermal_shutdown_flag_block;
  logic thermal_warning_flag_block;
  logic irq_active;
  logic restart_ok;

  localparam logic [7:0] STARTUP_LOAD = 8'(STARTUP_CYCLES - 1);

  // Access decode, shared by the write and read paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ******************************************************************
  // Thermal indications and flags
  // ******************************************************************
  // R19: comparator levels are synchronised
  pet_therm_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .raw_in({temp_above_restart_in, temp_above_shut_in, temp_above_warn_in}),
    .tif(tif.sync_side)
  );

  pet_event_flags u_flags (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .tif(tif.flag_side)
  );

  // R20: reading the flag register clears
  assign tif.flag_read = reg_rd_in && hit(reg_addr_in, `PET_OFS_FLAGS);

  // ******************************************************************
  // Field aliases
  // ******************************************************************
  assign soft_low_power = output_enable_control[`PET_EN_SLEEP_BIT];
  assign soft_voltage_select = output_enable_control[`PET_EN_VSEL_BIT];
  assign thermal_restart_keep_regs = output_discharge_control[`PET_PD_KEEP_BIT];
  assign thermal_shutdown_flag_block = thermal_event_mask[`PET_TH_SHUT_BIT];
  assign thermal_warning_flag_block = thermal_event_mask[`PET_TH_WARN_BIT];

  assign wr_enable = reg_wr_in && hit(reg_addr_in, `PET_OFS_ENABLE);
  assign wr_discharge = reg_wr_in && hit(reg_addr_in, `PET_OFS_DISCHARGE);
  assign wr_mask = reg_wr_in && hit(reg_addr_in, `PET_OFS_MASK);

  // ******************************************************************
  // Power state sequencing
  // ******************************************************************
  // R17: cooled below the restart level only
  assign restart_ok = !tif.shut_hot && !tif.restart_hot;

  // Shutdown wins over every other request, from any state
  always_comb begin
    next_power_state = power_state;
    unique case (power_state)
      PET_STANDBY: begin
        if (tif.shut_hot) begin
          next_power_state = PET_SHUTDOWN;
        end else if (en_pin_in) begin
          next_power_state = PET_STARTUP;
        end
      end
      PET_STARTUP: begin
        if (tif.shut_hot) begin
          next_power_state = PET_SHUTDOWN;
        end else if (!en_pin_in) begin
          next_power_state = PET_STANDBY;
        end else if (startup_count == 8'h00) begin
          next_power_state = PET_IDLE;
        end
      end
      PET_IDLE: begin
        // R16: emergency shutdown of all rails
        if (tif.shut_hot) begin
          next_power_state = PET_SHUTDOWN;
        end else if (!en_pin_in) begin
          next_power_state = PET_STANDBY;
        end
      end
      PET_SHUTDOWN: begin
        // R7: automatic restart when cool
        if (restart_ok && en_pin_in) begin
          next_power_state = PET_STARTUP;
        end else if (restart_ok) begin
          next_power_state = PET_STANDBY;
        end
      end
    endcase
  end

  // R8: reload defaults before restart
  assign reload_defaults = (power_state == PET_SHUTDOWN) && (next_power_state == PET_STARTUP)
                           && !thermal_restart_keep_regs;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power_state <= PET_STANDBY;
    end else begin
      power_state <= next_power_state;
    end
  end

  // Fixed dwell in start-up of STARTUP_CYCLES cycles for all rails together
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      startup_count <= 8'h00;
    end else if (power_state != PET_STARTUP) begin
      startup_count <= STARTUP_LOAD;
    end else if (startup_count != 8'h00) begin
      startup_count <= startup_count - 8'h01;
    end
  end

  // ******************************************************************
  // Writable registers
  // ******************************************************************
  // R1: staged bits only, rails untouched
  // A host write in the reload cycle is lost; the reload wins
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      output_enable_control <= `PET_RST_ENABLE;
    end else if (reload_defaults) begin
      output_enable_control <= `PET_RST_ENABLE;
    end else if (wr_enable) begin
      output_enable_control <= reg_wdata_in;
    end
  end

  // Bit 6 has no function and reads as zero
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      output_discharge_control <= `PET_RST_DISCHARGE;
    end else if (reload_defaults) begin
      output_discharge_control <= `PET_RST_DISCHARGE;
    end else if (wr_discharge) begin
      output_discharge_control <= reg_wdata_in & `PET_WMASK_DISCHARGE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      thermal_event_mask <= `PET_RST_MASK;
    end else if (reload_defaults) begin
      thermal_event_mask <= `PET_RST_MASK;
    end else if (wr_mask) begin
      thermal_event_mask <= reg_wdata_in & `PET_WMASK_MASK;
    end
  end

  // ******************************************************************
  // Register read path
  // ******************************************************************
  // Read valid follows each strobe by one edge
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // Read-only and unmapped offsets ignore writes; unmapped reads give zero
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          `PET_OFS_ENABLE: reg_rdata_out <= output_enable_control;
          `PET_OFS_DISCHARGE: reg_rdata_out <= output_discharge_control;
          // R9: shutdown bit from power state
          // R10: warning bit follows the level
          `PET_OFS_STATUS: reg_rdata_out <= {6'h00, power_state == PET_SHUTDOWN, tif.warn_hot};
          // R15: latched warning bit readable
          `PET_OFS_FLAGS: reg_rdata_out <= {6'h00, tif.shut_flag, tif.warn_flag};
          `PET_OFS_MASK: reg_rdata_out <= thermal_event_mask;
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // ******************************************************************
  // Regulator control outputs
  // ******************************************************************
  // R2: idle follows enable bits at once
  // Standby, start-up dwell and shutdown hold every rail off
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rail_on_out <= '0;
    end else if (next_power_state == PET_IDLE) begin
      rail_on_out <= output_enable_control[`PET_RAIL_COUNT-1:0];
    end else begin
      rail_on_out <= '0;
    end
  end

  // R6: pulldown bits per rail
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rail_discharge_out <= '0;
    end else begin
      rail_discharge_out <= output_discharge_control[`PET_RAIL_COUNT-1:0];
    end
  end

  // R4: pin control overrides the sleep bit
  // Both selects share one pin, so a low pin gives sleep and code b together
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_power_out <= 1'b0;
    end else begin
      low_power_out <= pin_low_power_ctrl_in ? !dvs_pin_in : soft_low_power;
    end
  end

  // R5: pin control overrides voltage select
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      converter_code_a_sel_out <= 1'b0;
    end else begin
      converter_code_a_sel_out <= pin_voltage_ctrl_in ? dvs_pin_in : soft_voltage_select;
    end
  end

  // Registered twin of the state, so the pins never see decode glitches
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power_state_out <= PET_STANDBY;
    end else begin
      power_state_out <= next_power_state;
    end
  end

  // ******************************************************************
  // Interrupt pin
  // ******************************************************************
  // R13: shutdown mask gates the line
  // R14: warning mask gates the line
  // Flags latch even while masked, so unmasking later pulls the line low
  assign irq_active = (tif.shut_flag && !thermal_shutdown_flag_block)
                      || (tif.warn_flag && !thermal_warning_flag_block);

  // R20: line low while unmasked flag
  // R18: one clock drives all state
  // Open drain: the pin is only ever pulled low, never driven high
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_n_oe_out <= 1'b0;
      irq_n_out <= 1'b1;
    end else begin
      irq_n_oe_out <= irq_active;
      irq_n_out <= !irq_active;
    end
  end
endmodule : pet_regs

`default_nettype wire

// file: logic/pet_therm_if.sv
/*
  Carrier for synchronised temperature indications and thermal event flags
  between the synchroniser, the flag latch and the register core.
  Assumes all three parties run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface pet_therm_if;
  logic warn_hot;
  logic shut_hot;
  logic restart_hot;
  logic warn_flag;
  logic shut_flag;
  logic flag_read;

  modport sync_side (output warn_hot, output shut_hot, output restart_hot);
  modport flag_side (input warn_hot, input shut_hot, input flag_read, output warn_flag, output shut_flag);
  modport core_side (input warn_hot, input shut_hot, input restart_hot, input warn_flag, input shut_flag,
                     output flag_read);
endinterface : pet_therm_if

`default_nettype wire

// file: logic/pet_therm_sync.sv
/*
  Two-stage synchronisers for the three temperature comparator levels.
  Assumes the comparators switch freely with respect to sys_clk_in.
*/
`timescale 1ns/100ps
`default_nettype none

module pet_therm_sync (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [2:0] raw_in,
  pet_therm_if.sync_side tif
);
  logic [2:0] stage_a;
  logic [2:0] stage_b;

  // The first stage feeds only the second
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage_a <= 3'h0;
      stage_b <= 3'h0;
    end else begin
      stage_a <= raw_in;
      stage_b <= stage_a;
    end
  end

  assign tif.warn_hot = stage_b[0];
  assign tif.shut_hot = stage_b[1];
  assign tif.restart_hot = stage_b[2];
endmodule : pet_therm_sync

`default_nettype wire

// file: tb/pet_host_model.sv
/*
  Host side of the byte register port: one access per bench command.
  Assumes commands come only after rsp_done_out of the previous one.
*/
`timescale 1ns/100ps
`default_nettype none

module pet_host_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Bench commands
  input wire logic cmd_go_in,
  input wire logic cmd_wr_in,
  input wire logic [7:0] cmd_addr_in,
  input wire logic [7:0] cmd_wdata_in,
  output logic [7:0] rsp_data_out,
  output logic rsp_done_out,
  // Register port
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire pet_pkg::pet_byte_t reg_rdata_in,
  input wire logic reg_rvalid_in
);
  logic busy;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy <= 1'b0;
      rsp_done_out <= 1'b0;
      rsp_data_out <= 8'h00;
      reg_addr_out <= 8'h00;
      reg_wdata_out <= 8'h00;
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
    end else begin
      rsp_done_out <= 1'b0;
      if (reg_wr_out || reg_rd_out) begin
        // Released lines flip, so a stale address is never mistaken for a live one
        reg_wr_out <= 1'b0;
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~reg_addr_out;
        reg_wdata_out <= ~reg_wdata_out;
        busy <= !reg_wr_out;
        rsp_done_out <= reg_wr_out;
      end else if (busy && reg_rvalid_in) begin
        rsp_data_out <= reg_rdata_in;
        busy <= 1'b0;
        rsp_done_out <= 1'b1;
      end else if (cmd_go_in && !busy) begin
        reg_addr_out <= cmd_addr_in;
        reg_wdata_out <= cmd_wdata_in;
        reg_wr_out <= cmd_wr_in;
        reg_rd_out <= !cmd_wr_in;
        busy <= 1'b1;
      end
    end
  end
endmodule : pet_host_model

`default_nettype wire

// file: tb/pet_regs_assertions.sv
/*
  Checker of the register group's port behaviour.
  Assumes it is bound onto pet_regs and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none

`include "pet_map.svh"

module pet_regs_assertions #(
  parameter int STARTUP_CYCLES = 4
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Register port and pins
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire pet_pkg::pet_byte_t reg_rdata_out,
  input wire logic dvs_pin_in,
  input wire logic pin_low_power_ctrl_in,
  input wire logic temp_above_shut_in,
  input wire logic temp_above_restart_in,
  // Observed outputs
  input wire logic [5:0] rail_on_out,
  input wire logic [5:0] rail_discharge_out,
  input wire logic low_power_out,
  input wire pet_pkg::pet_power_e power_state_out,
  input wire logic irq_n_out,
  input wire logic irq_n_oe_out
);
  import pet_pkg::*;

  logic [7:0] startup_cnt;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  // Dwell counter, so the startup length is checked without long repetitions
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      startup_cnt <= 8'h00;
    else if (power_state_out == PET_STARTUP)
      startup_cnt <= startup_cnt + 8'h01;
    else
      startup_cnt <= 8'h00;
  end

  a_shut_entry: assert property ($rose(temp_above_shut_in) |-> ##[1:4] power_state_out == PET_SHUTDOWN)
    else $error("shutdown not entered");
  a_rails_off_outside: assert property (power_state_out != PET_IDLE |-> rail_on_out == 6'h00)
    else $error("rail on outside idle");
  a_no_hot_restart: assert property (temp_above_restart_in[*3] ##0 power_state_out == PET_SHUTDOWN
    |=> power_state_out == PET_SHUTDOWN)
    else $error("left shutdown while hot");
  a_idle_enable_write: assert property ((power_state_out == PET_IDLE && reg_wr_in &&
    reg_addr_in == `PET_OFS_ENABLE) ##1 power_state_out == PET_IDLE ##1 power_state_out == PET_IDLE
    |-> rail_on_out == $past(reg_wdata_in[5:0], 2))
    else $error("idle enable write not applied");
  a_startup_dwell: assert property (power_state_out == PET_IDLE && $past(power_state_out) == PET_STARTUP
    |-> startup_cnt == 8'(STARTUP_CYCLES))
    else $error("startup dwell wrong");
  a_irq_release: assert property ($fell(irq_n_oe_out) |-> $past(reg_rd_in, 2) || $past(reg_rd_in, 3) ||
    $past(reg_wr_in, 2) || $past(reg_wr_in, 3) || power_state_out == PET_STARTUP)
    else $error("interrupt released without cause");
  a_irq_pin_pair: assert property (irq_n_oe_out |-> !irq_n_out)
    else $error("interrupt level and enable disagree");
  a_status_shut: assert property (reg_rd_in && reg_addr_in == `PET_OFS_STATUS |=>
    reg_rdata_out[7:1] == {6'h00, $past(power_state_out) == PET_SHUTDOWN})
    else $error("status shutdown bit wrong");
  a_discharge_write: assert property (reg_wr_in && reg_addr_in == `PET_OFS_DISCHARGE
    |=> ##1 rail_discharge_out == $past(reg_wdata_in[5:0], 2))
    else $error("discharge write not applied");
  a_pin_sleep: assert property ($past(pin_low_power_ctrl_in) |-> low_power_out == !$past(dvs_pin_in))
    else $error("pin sleep control wrong");
endmodule : pet_regs_assertions

bind pet_regs pet_regs_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .dvs_pin_in(dvs_pin_in),
  .pin_low_power_ctrl_in(pin_low_power_ctrl_in), .temp_above_shut_in(temp_above_shut_in),
  .temp_above_restart_in(temp_above_restart_in), .rail_on_out(rail_on_out),
  .rail_discharge_out(rail_discharge_out), .low_power_out(low_power_out),
  .power_state_out(power_state_out), .irq_n_out(irq_n_out), .irq_n_oe_out(irq_n_oe_out)
);

`default_nettype wire

// file: tb/tb_pet_regs.sv
/*
  Self-checking bench of the register group: host accesses, pins, thermal levels.
  Assumes the host model and the bound checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_pet_regs;
  import pet_pkg::*;

  localparam int SC = 2;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic go = 1'b0;
  logic wr_cmd = 1'b0;
  logic [7:0] c_addr = 8'h00;
  logic [7:0] c_wdata = 8'h00;
  logic en = 1'b0, dvs = 1'b0, lp_ctl = 1'b0, v_ctl = 1'b0;
  logic t_warn = 1'b0, t_shut = 1'b0, t_rest = 1'b0;
  logic [7:0] rsp, r_addr, r_wdata;
  logic done, r_wr, r_rd, rvalid, lp, csel, irq_n, irq_oe;
  pet_byte_t rdata;
  pet_power_e state;
  logic [5:0] rails, disch;
  int err_count = 0;
  int checked = 0;
  // Open-drain line with its pull-up
  wire irq_line = irq_oe ? 1'b0 : 1'b1;

  always #10 sys_clk_in = ~sys_clk_in;

  pet_host_model u_host (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .cmd_go_in(go), .cmd_wr_in(wr_cmd),
    .cmd_addr_in(c_addr), .cmd_wdata_in(c_wdata), .rsp_data_out(rsp), .rsp_done_out(done),
    .reg_addr_out(r_addr), .reg_wdata_out(r_wdata), .reg_wr_out(r_wr), .reg_rd_out(r_rd),
    .reg_rdata_in(rdata), .reg_rvalid_in(rvalid)
  );

  pet_regs #(.STARTUP_CYCLES(SC)) DUT (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(r_addr), .reg_wdata_in(r_wdata),
    .reg_wr_in(r_wr), .reg_rd_in(r_rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .en_pin_in(en), .dvs_pin_in(dvs), .pin_low_power_ctrl_in(lp_ctl), .pin_voltage_ctrl_in(v_ctl),
    .temp_above_warn_in(t_warn), .temp_above_shut_in(t_shut), .temp_above_restart_in(t_rest),
    .rail_on_out(rails), .rail_discharge_out(disch), .low_power_out(lp), .converter_code_a_sel_out(csel),
    .power_state_out(state), .irq_n_out(irq_n), .irq_n_oe_out(irq_oe)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge sys_clk_in);
    go <= 1'b1;
    wr_cmd <= w;
    c_addr <= a;
    c_wdata <= d;
    @(posedge sys_clk_in);
    go <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge sys_clk_in);
      // Value settled at the edge before, so no race with the model
      if (done === 1'b1) break;
    end
    if (done !== 1'b1) err_count++;
  endtask : acc

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(rsp, exp);
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : cyc

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial begin
    cyc(12);
    arst_n_in <= 1'b1;
    rd_chk(8'h08, 8'h8F);
    rd_chk(8'h09, 8'h3F);
    rd_chk(8'h0C, 8'h03);
    acc(1'b1, 8'h0A, 8'hFF);
    acc(1'b1, 8'h0B, 8'hFF);
    acc(1'b1, 8'h0D, 8'hFF);
    acc(1'b1, 8'h09, 8'hFF);
    acc(1'b1, 8'h0C, 8'hFF);
    rd_chk(8'h0A, 8'h00);
    rd_chk(8'h0B, 8'h00);
    rd_chk(8'h0D, 8'h00);
    rd_chk(8'h09, 8'hBF);
    rd_chk(8'h0C, 8'h03);
    acc(1'b1, 8'h08, 8'h85);
    chk({2'b00, rails}, 8'h00);
    en <= 1'b1;
    cyc(SC + 4);
    chk({6'h00, state}, {6'h00, PET_IDLE});
    chk({2'b00, rails}, 8'h05);
    acc(1'b1, 8'h08, 8'h4A);
    cyc(2);
    chk({2'b00, rails}, 8'h0A);
    chk({lp, csel}, 8'h02);
    acc(1'b1, 8'h08, 8'h8A);
    cyc(2);
    chk({lp, csel}, 8'h01);
    lp_ctl <= 1'b1;
    v_ctl <= 1'b1;
    cyc(3);
    chk({lp, csel}, 8'h02);
    dvs <= 1'b1;
    cyc(3);
    chk({lp, csel}, 8'h01);
    lp_ctl <= 1'b0;
    v_ctl <= 1'b0;
    acc(1'b1, 8'h09, 8'h95);
    cyc(2);
    chk({2'b00, disch}, 8'h15);
    acc(1'b1, 8'h0C, 8'h00);
    t_warn <= 1'b1;
    cyc(6);
    chk({irq_line, irq_oe}, 8'h01);
    rd_chk(8'h0A, 8'h01);
    rd_chk(8'h0B, 8'h01);
    cyc(2);
    chk(irq_line, 8'h01);
    rd_chk(8'h0B, 8'h00);
    acc(1'b1, 8'h0C, 8'h01);
    t_warn <= 1'b0;
    cyc(4);
    t_warn <= 1'b1;
    cyc(6);
    chk(irq_line, 8'h01);
    rd_chk(8'h0B, 8'h01);
    t_warn <= 1'b0;
    acc(1'b1, 8'h08, 8'h83);
    t_shut <= 1'b1;
    t_rest <= 1'b1;
    cyc(6);
    chk({6'h00, state}, {6'h00, PET_SHUTDOWN});
    chk({2'b00, rails}, 8'h00);
    chk(irq_line, 8'h00);
    rd_chk(8'h0A, 8'h02);
    t_shut <= 1'b0;
    cyc(10);
    chk({6'h00, state}, {6'h00, PET_SHUTDOWN});
    t_rest <= 1'b0;
    cyc(SC + 6);
    chk({2'b00, rails}, 8'h03);
    rd_chk(8'h08, 8'h83);
    rd_chk(8'h0B, 8'h02);
    acc(1'b1, 8'h09, 8'h15);
    acc(1'b1, 8'h0C, 8'h00);
    t_shut <= 1'b1;
    t_rest <= 1'b1;
    cyc(6);
    t_shut <= 1'b0;
    t_rest <= 1'b0;
    cyc(SC + 8);
    rd_chk(8'h08, 8'h8F);
    rd_chk(8'h09, 8'h3F);
    chk(irq_line, 8'h01);
    chk({2'b00, rails}, 8'h0F);
    test_done();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    cyc(5000);
    err_count++;
    test_done();
  end
endmodule : tb_pet_regs

`default_nettype wire
